// ### common/fan_defs.vh
`ifndef FAN_DEFS_VH
`define FAN_DEFS_VH

// Overview of operation
// - PWM output runs at full duty after power-up and after leaving shutdown.
// - PWM output stops only while the shutdown bit is set.
// - A stalled rotor never stops the PWM; it keeps the programmed duty.
// - Two-bit fields per fan select 1, 2, 4 or 8 pulses per revolution.
// - Both pulses-per-revolution fields reset to two pulses per revolution.
// - Each fan speed is a 9-bit read-only value, 25 RPM per step.
// - Resolution bit 1 reads 25 RPM steps; 0 reads 8-bit 50 RPM steps.
// - Speed above 12775 RPM sets that fan's overflow status bit, 3 or 4.
// - Overflow bit clears itself after 2.4 s of readings below maximum.
// - Each fan has an 8-bit read/write low-speed threshold register.
// - Both threshold registers reset to the code for 500 RPM.
// - Low-speed fault only after speed stays below threshold for 2.4 s.
// - Low-speed fault pulls the fault pin low and sets status bit 0 or 1.
// - Writing 1 to configuration bit 7 clears the low-speed flags and their fault pin drive.
// - Demand above full duty sets status bit 5 and may pull fault pin low.
// - Demand back within range clears bit 5 and releases that fault drive.
// - Shutdown suspends everything except the serial register interface.
// - Normal operation resumes at once when the shutdown bit is cleared.
// - Leaving shutdown restores defaults except configuration and threshold registers.
// - Serial slave answers only the fixed 7-bit address 0011011.
// - Data stable while clock high; changes then are start or stop.
// - Configuration bit 5 picks duty source: 0 temperature input, 1 duty register.
// - Duty register is 4 bits mapping linearly from 30 to 100 percent.
// - Full-duty start-up lasts one second, then the chosen source applies.

// Clock and timing
`define CLK_HZ           125000000
`define GATE_TIME_MS     2400
`define GATE_CYCLES      29'h11E1_A300 // 2.4 s of clock cycles
`define STARTUP_TIME_MS  1000
`define STARTUP_CYCLES   29'h0773_5940 // 1 s of clock cycles
`define PWM_FREQ_HZ      30
`define PWM_TICK_CYCLES  16'h6C81 // 150 steps per 30 Hz period
`define PWM_LAST_STEP    8'h95
`define PWM_BASE_STEPS   8'h2D

// Serial slave address and register offsets
`define SMB_ADDR         7'h1B
`define REG_FAN1_SPEED   8'h00
`define REG_FAN2_SPEED   8'h01
`define REG_FAN1_THR     8'h02
`define REG_FAN2_THR     8'h03
`define REG_CONFIG       8'h04
`define REG_STATUS       8'h05
`define REG_DUTY         8'h06
`define REG_SPEED_MSB    8'h07

// Configuration fields
`define CFG_SDM          0
`define CFG_FAN1_PULSES_PER_REV        1
`define CFG_FAN2_PULSES_PER_REV        3
`define CFG_DUTY_SRC     5
`define CFG_RES          6
`define CFG_FCLR         7

// Status fields
`define ST_LOW1          0
`define ST_LOW2          1
`define ST_OVF1          3
`define ST_OVF2          4
`define ST_OTF           5

// Reset values and limits
`define CFG_RESET        8'h0A
`define THR_RESET        8'h0A
`define DUTY_RESET       4'h2
`define SPEED_MAX        9'h1FF
`define DUTY_MAX_CODE    5'h0F

`endif

// ### src/fan_ctrl.v
`timescale 1ns/1ns
`include "fan_defs.vh"

module fan_ctrl #(
  parameter [28:0] GATE_CYCLES     = `GATE_CYCLES,
  parameter [28:0] STARTUP_CYCLES  = `STARTUP_CYCLES,
  parameter [15:0] PWM_TICK_CYCLES = `PWM_TICK_CYCLES,
  parameter        OTF_DRIVES_FAULT = 1
) (
  input  wire       clk,
  input  wire       reset,
  input  wire       scl_in,
  input  wire       sda_in,
  output wire       sda_out,
  output wire       sda_oe,
  input  wire       fan1_pulse_in,
  input  wire       fan2_pulse_in,
  input  wire [4:0] temperature_voltage_in,
  output wire       pwm_drive_out,
  output wire       fault_out,
  output wire       fault_oe
);

  // Serial states
  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_ADDR = 5'b00010;
  localparam [4:0] ST_CMD  = 5'b00100;
  localparam [4:0] ST_WR   = 5'b01000;
  localparam [4:0] ST_RD   = 5'b10000;

  // Pin synchronisers
  reg       scl_s1_q;
  reg       scl_s2_q;
  reg       scl_d_q;
  reg       sda_s1_q;
  reg       sda_s2_q;
  reg       sda_d_q;
  reg [4:0] temp_s1_q;
  reg [4:0] temp_s2_q;

  // Serial slave state
  reg [4:0] state_q;
  reg [3:0] bit_cnt_q;
  reg [7:0] shift_q;
  reg [7:0] tx_q;
  reg [7:0] ptr_q;
  reg       rw_q;
  reg       sda_oe_q;
  reg       sda_out_q;
  reg       wr_stb_q;
  reg [7:0] wr_data_q;

  // Register file
  reg [7:0] configuration_q;
  reg [7:0] fan1_speed_threshold_q;
  reg [7:0] fan2_speed_threshold_q;
  reg [3:0] duty_q;
  reg       fclr_q;

  // Operating state
  reg [28:0] gate_cnt_q;
  reg        gate_stb_q;
  reg [28:0] start_cnt_q;
  reg        startup_q;
  reg        otf_q;
  reg        fault_oe_q;
  reg        fault_out_q;
  reg [3:0]  duty_code_q;
  reg [7:0]  rdata;

  wire       shutdown_bit         = configuration_q[`CFG_SDM];
  wire [1:0] fan1_pulses_per_rev  = configuration_q[`CFG_FAN1_PULSES_PER_REV +: 2];
  wire [1:0] fan2_pulses_per_rev  = configuration_q[`CFG_FAN2_PULSES_PER_REV +: 2];
  wire       duty_source_select   = configuration_q[`CFG_DUTY_SRC];
  wire       speed_resolution_bit = configuration_q[`CFG_RES];

  // Everything but the serial port and its kept registers sits in reset
  wire func_rst = reset | shutdown_bit;

  wire scl_rise = scl_s2_q & ~scl_d_q;
  wire scl_fall = ~scl_s2_q & scl_d_q;
  wire start_ev = scl_s2_q & scl_d_q & sda_d_q & ~sda_s2_q;
  wire stop_ev  = scl_s2_q & scl_d_q & ~sda_d_q & sda_s2_q;

  wire [1:0]  pulse_w = {fan2_pulse_in, fan1_pulse_in};
  wire [3:0]  ppr_w   = {fan2_pulses_per_rev, fan1_pulses_per_rev};
  wire [15:0] thr_w   = {fan2_speed_threshold_q, fan1_speed_threshold_q};
  wire [17:0] speed_w;
  wire [1:0]  low_w;
  wire [1:0]  ovf_w;

  wire fan1_low_speed_flag = low_w[0];
  wire fan2_low_speed_flag = low_w[1];
  wire fan1_overflow_flag  = ovf_w[0];
  wire fan2_overflow_flag  = ovf_w[1];
  wire overtemp_flag       = otf_q;

  wire [8:0] fan1_speed = speed_w[8:0];
  wire [8:0] fan2_speed = speed_w[17:9];

  wire [7:0] fault_status = {2'b00, overtemp_flag, fan2_overflow_flag,
                             fan1_overflow_flag, 1'b0, fan2_low_speed_flag,
                             fan1_low_speed_flag};

  // Demanded code, above 15 means beyond full duty
  wire [4:0] demand = duty_source_select ? {1'b0, duty_q} : temp_s2_q;

  assign sda_out       = sda_out_q;
  assign sda_oe        = sda_oe_q;
  assign fault_out     = fault_out_q;
  assign fault_oe      = fault_oe_q;

  // Two-flop capture of bus pins and temperature code
  always @(posedge clk) begin
    if (reset) begin
      scl_s1_q  <= 1'b1;
      scl_s2_q  <= 1'b1;
      scl_d_q   <= 1'b1;
      sda_s1_q  <= 1'b1;
      sda_s2_q  <= 1'b1;
      sda_d_q   <= 1'b1;
      temp_s1_q <= 5'h00;
      temp_s2_q <= 5'h00;
    end else begin
      scl_s1_q  <= scl_in;
      scl_s2_q  <= scl_s1_q;
      scl_d_q   <= scl_s2_q;
      sda_s1_q  <= sda_in;
      sda_s2_q  <= sda_s1_q;
      sda_d_q   <= sda_s2_q;
      temp_s1_q <= temperature_voltage_in;
      temp_s2_q <= temp_s1_q;
    end
  end

  // Read data selected by the command pointer
  always @* begin
    case (ptr_q)
      `REG_FAN1_SPEED: rdata = speed_resolution_bit ? fan1_speed[7:0] : fan1_speed[8:1];
      `REG_FAN2_SPEED: rdata = speed_resolution_bit ? fan2_speed[7:0] : fan2_speed[8:1];
      `REG_FAN1_THR:   rdata = fan1_speed_threshold_q;
      `REG_FAN2_THR:   rdata = fan2_speed_threshold_q;
      `REG_CONFIG:     rdata = configuration_q;
      `REG_STATUS:     rdata = fault_status;
      `REG_DUTY:       rdata = {4'h0, duty_q};
      `REG_SPEED_MSB:  rdata = {6'h00, fan2_speed[8], fan1_speed[8]};
      default:         rdata = 8'h00;
    endcase
  end

  // Serial slave: address, command, write data and read data bytes
  always @(posedge clk) begin
    if (reset) begin
      state_q   <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
      tx_q      <= 8'h00;
      ptr_q     <= 8'h00;
      rw_q      <= 1'b0;
      sda_oe_q  <= 1'b0;
      sda_out_q <= 1'b0;
      wr_stb_q  <= 1'b0;
      wr_data_q <= 8'h00;
    end else begin
      wr_stb_q <= 1'b0;
      if (start_ev) begin
        state_q   <= ST_ADDR;
        bit_cnt_q <= 4'hF; // First fall after start carries no bit
        sda_oe_q  <= 1'b0;
      end else if (stop_ev) begin
        state_q  <= ST_IDLE;
        sda_oe_q <= 1'b0;
      end else if (scl_rise && state_q != ST_IDLE) begin
        if (bit_cnt_q != 4'h8 && state_q != ST_RD)
          shift_q <= {shift_q[6:0], sda_s2_q};
        // Master leaves ack high after the last read byte
        if (bit_cnt_q == 4'h8 && state_q == ST_RD && sda_s2_q)
          state_q <= ST_IDLE;
      end else if (scl_fall && state_q != ST_IDLE) begin
        case (bit_cnt_q)
          4'h7: begin
            bit_cnt_q <= 4'h8;
            case (state_q)
              ST_ADDR: begin
                rw_q <= shift_q[0];
                if (shift_q[7:1] == `SMB_ADDR)
                  sda_oe_q <= 1'b1;
                else
                  state_q <= ST_IDLE;
              end
              ST_CMD: begin
                ptr_q    <= shift_q;
                sda_oe_q <= 1'b1;
              end
              ST_WR: begin
                wr_stb_q  <= 1'b1;
                wr_data_q <= shift_q;
                sda_oe_q  <= 1'b1;
              end
              default: sda_oe_q <= 1'b0;
            endcase
          end
          4'h8: begin
            bit_cnt_q <= 4'h0;
            case (state_q)
              ST_ADDR: state_q <= rw_q ? ST_RD : ST_CMD;
              ST_CMD:  state_q <= ST_WR;
              default: state_q <= state_q;
            endcase
            // Load and present the first read bit
            if (state_q == ST_RD || (state_q == ST_ADDR && rw_q)) begin
              tx_q     <= {rdata[6:0], 1'b0};
              sda_oe_q <= ~rdata[7];
            end else begin
              sda_oe_q <= 1'b0;
            end
          end
          default: begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (state_q == ST_RD) begin
              sda_oe_q <= ~tx_q[7];
              tx_q     <= {tx_q[6:0], 1'b0};
            end
          end
        endcase
      end
    end
  end

  // Kept registers: configuration and thresholds survive shutdown
  always @(posedge clk) begin
    if (reset) begin
      configuration_q        <= `CFG_RESET;
      fan1_speed_threshold_q <= `THR_RESET;
      fan2_speed_threshold_q <= `THR_RESET;
      fclr_q                 <= 1'b0;
    end else begin
      fclr_q <= 1'b0;
      if (wr_stb_q) begin
        case (ptr_q)
          `REG_CONFIG: begin
            configuration_q <= {1'b0, wr_data_q[6:0]};
            fclr_q          <= wr_data_q[`CFG_FCLR];
          end
          `REG_FAN1_THR: fan1_speed_threshold_q <= wr_data_q;
          `REG_FAN2_THR: fan2_speed_threshold_q <= wr_data_q;
          default: fclr_q <= 1'b0;
        endcase
      end
    end
  end

  // Duty register returns to default on leaving shutdown
  always @(posedge clk) begin
    if (func_rst)
      duty_q <= `DUTY_RESET;
    else if (wr_stb_q && ptr_q == `REG_DUTY)
      duty_q <= wr_data_q[3:0];
  end

  // Start-up full duty window after reset or shutdown exit
  always @(posedge clk) begin
    if (func_rst) begin
      start_cnt_q <= 29'h0000_0000;
      startup_q   <= 1'b1;
    end else if (startup_q) begin
      if (start_cnt_q == STARTUP_CYCLES - 29'h0000_0001)
        startup_q <= 1'b0;
      else
        start_cnt_q <= start_cnt_q + 29'h0000_0001;
    end
  end

  // Speed gate, one strobe per 2.4 s
  always @(posedge clk) begin
    if (func_rst) begin
      gate_cnt_q <= 29'h0000_0000;
      gate_stb_q <= 1'b0;
    end else begin
      gate_stb_q <= (gate_cnt_q == GATE_CYCLES - 29'h0000_0001);
      if (gate_cnt_q == GATE_CYCLES - 29'h0000_0001)
        gate_cnt_q <= 29'h0000_0000;
      else
        gate_cnt_q <= gate_cnt_q + 29'h0000_0001;
    end
  end

  // Per-fan measurement and status flags
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : gen_fan
      wire [8:0] spd;
      wire       ovf_now;
      wire       done;
      reg        low_q;
      reg        ovf_q;

      fan_speed_meas u_meas (
        .clk        (clk),
        .rst        (func_rst),
        .pulse_in   (pulse_w[i]),
        .ppr_sel    (ppr_w[2*i +: 2]),
        .gate_stb   (gate_stb_q),
        .speed_q    (spd),
        .overflow_q (ovf_now),
        .done_q     (done)
      );

      // Low-speed flag; a new fault wins over the clear strobe
      always @(posedge clk) begin
        if (func_rst)
          low_q <= 1'b0;
        else if (done && spd[8:1] < thr_w[8*i +: 8])
          low_q <= 1'b1;
        else if (fclr_q)
          low_q <= 1'b0;
      end

      // Overflow flag follows each full gate reading
      always @(posedge clk) begin
        if (func_rst)
          ovf_q <= 1'b0;
        else if (done)
          ovf_q <= ovf_now;
      end

      assign speed_w[9*i +: 9] = spd;
      assign low_w[i]          = low_q;
      assign ovf_w[i]          = ovf_q;
    end
  endgenerate

  // Over-temperature flag and applied duty code
  always @(posedge clk) begin
    if (func_rst) begin
      otf_q       <= 1'b0;
      duty_code_q <= `DUTY_RESET;
    end else begin
      otf_q       <= (demand > `DUTY_MAX_CODE);
      duty_code_q <= (demand > `DUTY_MAX_CODE) ? 4'hF : demand[3:0];
    end
  end

  // Open-drain fault pin, pulled low on a low-speed fault or, with OTF_DRIVES_FAULT, over-temperature
  always @(posedge clk) begin
    if (reset) begin
      fault_oe_q  <= 1'b0;
      fault_out_q <= 1'b0;
    end else begin
      fault_out_q <= 1'b0;
      fault_oe_q  <= low_w[0] | low_w[1] |
                     ((OTF_DRIVES_FAULT != 0) & otf_q);
    end
  end

  // PWM stage; only shutdown stops it, stalls leave duty alone
  fan_pwm_gen #(
    .TICK_CYCLES (PWM_TICK_CYCLES)
  ) u_pwm (
    .clk       (clk),
    .rst       (func_rst),
    .full_on   (startup_q),
    .duty_code (duty_code_q),
    .pwm_q     (pwm_drive_out)
  );

endmodule

// ### src/fan_pwm_gen.v
`timescale 1ns/1ns
`include "fan_defs.vh"

module fan_pwm_gen #(
  parameter [15:0] TICK_CYCLES = `PWM_TICK_CYCLES
) (
  input  wire       clk,
  input  wire       rst,
  input  wire       full_on,
  input  wire [3:0] duty_code,
  output reg        pwm_q
);

  reg [15:0] div_q;
  reg [7:0]  step_q;

  // 30 percent base plus seven steps per code out of 150
  wire [7:0] high_steps = `PWM_BASE_STEPS + {1'b0, duty_code, 3'b000} - {4'h0, duty_code};
  wire       tick       = (div_q == TICK_CYCLES - 16'h0001);

  // Step divider and PWM compare
  always @(posedge clk) begin
    if (rst) begin
      div_q  <= 16'h0000;
      step_q <= 8'h00;
      pwm_q  <= 1'b0;
    end else begin
      div_q <= tick ? 16'h0000 : div_q + 16'h0001;
      if (tick)
        step_q <= (step_q == `PWM_LAST_STEP) ? 8'h00 : step_q + 8'h01;
      pwm_q <= full_on | (step_q < high_steps);
    end
  end

endmodule

// ### src/fan_speed_meas.v
`timescale 1ns/1ns
`include "fan_defs.vh"

module fan_speed_meas (
  input  wire       clk,
  input  wire       rst,
  input  wire       pulse_in,
  input  wire [1:0] ppr_sel,
  input  wire       gate_stb,
  output reg  [8:0] speed_q,
  output reg        overflow_q,
  output reg        done_q
);

  reg        p1_q;
  reg        p2_q;
  reg        p3_q;
  reg [11:0] cnt_q;

  wire        edge_w  = p2_q & ~p3_q;
  wire [11:0] per_rev = cnt_q >> ppr_sel;

  // Pin synchroniser and edge detect
  always @(posedge clk) begin
    if (rst) begin
      p1_q <= 1'b0;
      p2_q <= 1'b0;
      p3_q <= 1'b0;
    end else begin
      p1_q <= pulse_in;
      p2_q <= p1_q;
      p3_q <= p2_q;
    end
  end

  // Pulse count over one gate, scaled per revolution
  always @(posedge clk) begin
    if (rst) begin
      cnt_q      <= 12'h000;
      speed_q    <= 9'h000;
      overflow_q <= 1'b0;
      done_q     <= 1'b0;
    end else begin
      done_q <= gate_stb;
      if (gate_stb) begin
        cnt_q <= {11'h000, edge_w};
        if (per_rev > {3'h0, `SPEED_MAX}) begin
          speed_q    <= `SPEED_MAX;
          overflow_q <= 1'b1;
        end else begin
          speed_q    <= per_rev[8:0];
          overflow_q <= 1'b0;
        end
      end else if (edge_w && cnt_q != 12'hFFF) begin
        cnt_q <= cnt_q + 12'h001;
      end
    end
  end

endmodule

// ### tb/fan_ctrl_checker.sv
`timescale 1ns/1ns
module fan_ctrl_checker #(
  parameter [28:0] GATE_CYCLES    = 29'h7D0,
  parameter [28:0] STARTUP_CYCLES = 29'h1F4
) (
  input wire       clk,
  input wire       reset,
  input wire       scl_in,
  input wire       sda_in,
  input wire       sda_out,
  input wire       sda_oe,
  input wire       fan1_pulse_in,
  input wire       fan2_pulse_in,
  input wire [4:0] temperature_voltage_in,
  input wire       pwm_drive_out,
  input wire       fault_out,
  input wire       fault_oe
);
  reg [28:0] up_q;
  // Cycles since reset release, saturating
  always @(posedge clk) begin
    if (reset)
      up_q <= 29'h0;
    else if (up_q != 29'h1FFF_FFFF)
      up_q <= up_q + 29'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sda_drive_low_a: assert property (!sda_out)
    else $error("data pin drive value not low");
  fault_drive_low_a: assert property (!fault_out)
    else $error("fault pin drive value not low");
  reset_quiet_a: assert property ($fell(reset) |-> !pwm_drive_out && !sda_oe && !fault_oe ##2 pwm_drive_out)
    else $error("outputs wrong after reset release");
  startup_full_a: assert property (up_q >= 29'h4 && up_q < STARTUP_CYCLES - 29'h4 |-> pwm_drive_out)
    else $error("drive not full during start-up");
  sda_stable_a: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in))
    else $error("data line changed while clock high");
  sda_hold_a: assert property ($rose(sda_oe) |-> sda_oe [*8])
    else $error("data pull released too early");
  otf_fault_a: assert property ((temperature_voltage_in > 5'h0F) [*8] |-> fault_oe)
    else $error("no fault pull on over-temperature");
  early_fault_a: assert property ((up_q < GATE_CYCLES && temperature_voltage_in <= 5'h0F) [*8] |-> !fault_oe)
    else $error("fault before a full gate");
endmodule

bind fan_ctrl fan_ctrl_checker #(.GATE_CYCLES(GATE_CYCLES), .STARTUP_CYCLES(STARTUP_CYCLES)) chk_i (
  .clk(clk), .reset(reset), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .fan1_pulse_in(fan1_pulse_in), .fan2_pulse_in(fan2_pulse_in),
  .temperature_voltage_in(temperature_voltage_in), .pwm_drive_out(pwm_drive_out),
  .fault_out(fault_out), .fault_oe(fault_oe)
);

// ### tb/smbus_host.sv
`timescale 1ns/1ns
module smbus_host (
  input  wire clk,
  input  wire dev_oe,
  output reg  scl,
  output wire sda
);
  reg low_q = 1'b0;
  initial scl = 1'b1;
  // Open-drain data line with pull-up
  assign sda = !(low_q || dev_oe);
  task automatic tick(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Data set while clock low, read at end of high
  task automatic bit_io(input reg b, output reg s);
    low_q = !b;
    tick(8);
    scl = 1'b1;
    tick(10);
    s = sda;
    scl = 1'b0;
    tick(2);
  endtask
  // Clock high with a data edge: start when falling, stop when rising
  task automatic cond(input reg d0, input reg d1);
    low_q = !d0;
    tick(5);
    scl = 1'b1;
    tick(10);
    low_q = !d1;
    tick(10);
  endtask
  task automatic start();
    cond(1'b1, 1'b0);
    scl = 1'b0;
    tick(2);
  endtask
  // Eight bits MSB first, acknowledge slot left released
  task automatic byte_io(input [7:0] d, output [7:0] q, output reg ack);
    integer i;
    reg     s;
    for (i = 7; i >= 0; i = i - 1) begin
      bit_io(d[i], s);
      q[i] = s;
    end
    bit_io(1'b1, s);
    ack = !s;
  endtask
  task automatic wr(input [7:0] a, input [7:0] c, input [7:0] d, output reg ok);
    reg [7:0] q;
    reg       a0, a1, a2;
    start();
    byte_io(a, q, a0);
    byte_io(c, q, a1);
    byte_io(d, q, a2);
    cond(1'b0, 1'b1);
    ok = a0 && a1 && a2;
  endtask
  // Read with repeated start; data byte ends with a not-acknowledge
  task automatic rd(input [7:0] c, output [7:0] q, output reg ok);
    reg [7:0] x;
    reg       a0, a1, a2, n;
    start();
    byte_io(8'h36, x, a0);
    byte_io(c, x, a1);
    start();
    byte_io(8'h37, x, a2);
    byte_io(8'hFF, q, n);
    cond(1'b0, 1'b1);
    ok = a0 && a1 && a2;
  endtask
endmodule

// ### tb/testbench.sv
`timescale 1ns/1ns
module testbench;
  reg        clk = 1'b0;
  reg        reset = 1'b1;
  reg        fan1_pulse_in = 1'b0;
  reg        fan2_pulse_in = 1'b0;
  reg  [4:0] temperature_voltage_in = 5'h00;
  wire       scl, sda, sda_out, sda_oe, pwm_drive_out, fault_out, fault_oe;
  integer    err_total = 0;
  integer    check_count = 0;
  integer    half1 = 5;
  integer    half2 = 0;
  reg  [7:0] rdat;
  reg        ok;
  localparam W = 4000;
  always #4 clk = ~clk;
  // Tach sources, zero half period means a stalled fan
  always begin
    repeat (half1 == 0 ? 1 : half1) @(posedge clk);
    #1 if (half1 != 0) fan1_pulse_in = ~fan1_pulse_in;
  end
  always begin
    repeat (half2 == 0 ? 1 : half2) @(posedge clk);
    #1 if (half2 != 0) fan2_pulse_in = ~fan2_pulse_in;
  end
  fan_ctrl #(.GATE_CYCLES(29'h7D0), .STARTUP_CYCLES(29'h1F4), .PWM_TICK_CYCLES(16'h4), .OTF_DRIVES_FAULT(1)) DUT (
    .clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .fan1_pulse_in(fan1_pulse_in), .fan2_pulse_in(fan2_pulse_in),
    .temperature_voltage_in(temperature_voltage_in), .pwm_drive_out(pwm_drive_out),
    .fault_out(fault_out), .fault_oe(fault_oe)
  );
  smbus_host host (.clk(clk), .dev_oe(sda_oe), .scl(scl), .sda(sda));
  task automatic chk(input [15:0] g, input [15:0] e);
    check_count = check_count + 1;
    if (g !== e) begin
      err_total = err_total + 1;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cyc(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rd(input [7:0] c, input [7:0] e);
    host.rd(c, rdat, ok);
    chk(ok, 1'b1);
    chk(rdat, e);
  endtask
  task automatic wr(input [7:0] c, input [7:0] d);
    host.wr(8'h36, c, d, ok);
    chk(ok, 1'b1);
  endtask
  // High cycles of the drive over n cycles
  task automatic hi(input integer n, input integer e);
    integer i, h;
    h = 0;
    for (i = 0; i < n; i = i + 1) begin
      cyc(1);
      h = h + pwm_drive_out;
    end
    chk(h[15:0], e[15:0]);
  endtask
  task automatic t_reset();
    host.wr(8'h2A, 8'h04, 8'h01, ok);
    chk(ok, 1'b0);
    rd(8'h04, 8'h0A);
    rd(8'h02, 8'h0A);
    rd(8'h03, 8'h0A);
    rd(8'h06, 8'h02);
    rd(8'h09, 8'h00);
  endtask
  // Speed under each pulses-per-revolution choice, then half resolution
  task automatic t_speed();
    integer s, e;
    for (s = 0; s < 4; s = s + 1) begin
      wr(8'h04, 8'h48 | {s[1:0], 1'b0});
      cyc(W);
      host.rd(8'h00, rdat, ok);
      e = 200 >> s;
      chk(rdat + 1 >= e && rdat <= e + 1, 1'b1);
    end
    wr(8'h04, 8'h0A);
    cyc(W);
    host.rd(8'h00, rdat, ok);
    chk(rdat >= 49 && rdat <= 51, 1'b1);
    rd(8'h01, 8'h00);
  endtask
  task automatic t_fault();
    rd(8'h05, 8'h02);
    chk(fault_oe, 1'b1);
    hi(600, 180);
    half2 = 5;
    wr(8'h02, 8'h33);
    cyc(W);
    rd(8'h02, 8'h33);
    rd(8'h05, 8'h03);
    wr(8'h02, 8'h0A);
    cyc(W);
    wr(8'h04, 8'h8A);
    rd(8'h05, 8'h00);
    chk(fault_oe, 1'b0);
    half2 = 0;
    cyc(W);
    rd(8'h05, 8'h02);
    half2 = 5;
    cyc(W);
    wr(8'h04, 8'h8A);
  endtask
  task automatic t_over();
    wr(8'h04, 8'h48);
    half1 = 1;
    cyc(W);
    rd(8'h05, 8'h08);
    rd(8'h00, 8'hFF);
    rd(8'h07, 8'h01);
    half1 = 5;
    cyc(W);
    rd(8'h05, 8'h00);
  endtask
  task automatic t_duty();
    integer c;
    temperature_voltage_in = 5'h03;
    cyc(600);
    hi(600, 264);
    temperature_voltage_in = 5'h10;
    cyc(8);
    chk(fault_oe, 1'b1);
    rd(8'h05, 8'h20);
    temperature_voltage_in = 5'h03;
    cyc(8);
    chk(fault_oe, 1'b0);
    rd(8'h05, 8'h00);
    wr(8'h04, 8'h68);
    for (c = 0; c < 16; c = c + 5) begin
      wr(8'h06, c[7:0]);
      rd(8'h06, c[7:0]);
      hi(600, (45 + 7 * c) * 4);
    end
  endtask
  task automatic t_shut();
    wr(8'h03, 8'h21);
    wr(8'h04, 8'h69);
    hi(600, 0);
    rd(8'h03, 8'h21);
    wr(8'h04, 8'h68);
    hi(400, 400);
    rd(8'h04, 8'h68);
    rd(8'h03, 8'h21);
    rd(8'h06, 8'h02);
  endtask
  task automatic finish_test();
    $display("Checks %0d, errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    cyc(10);
    reset = 1'b0;
    cyc(3);
    t_reset();
    t_speed();
    t_fault();
    t_over();
    t_duty();
    t_shut();
    finish_test();
  end
  // Watchdog against a hang
  initial begin
    cyc(95000);
    chk(1'b0, 1'b1);
    finish_test();
  end
endmodule
